// ===== common/spcg_pkg.sv
package spcg_pkg;
	// register map, word offsets are byte addresses
	localparam logic [11:0] SLEEP_GATE_OFS = 12'h0114;
	localparam logic [11:0] RUN_GATE_OFS = 12'h0104;
	localparam logic [11:0] DEEP_GATE_OFS = 12'h0124;
	localparam logic [11:0] RUN_CFG_OFS = 12'h0060;
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;
	localparam logic [31:0] GATE_WMASK = 32'h0007_5031;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam int ACG_POS = 27;
	// field positions of the gate bits
	localparam int NUM_PERIPH = 8;
	localparam int UART_A_POS = 0;
	localparam int SYNC_A_POS = 4;
	localparam int SYNC_B_POS = 5;
	localparam int TWO_A_POS = 12;
	localparam int TWO_B_POS = 14;
	localparam int TIMER_0_POS = 16;
	localparam int TIMER_1_POS = 17;
	localparam int TIMER_2_POS = 18;
	localparam int GATE_POS [NUM_PERIPH] = '{UART_A_POS, SYNC_A_POS,
		SYNC_B_POS, TWO_A_POS, TWO_B_POS, TIMER_0_POS, TIMER_1_POS,
		TIMER_2_POS};
	// power modes
	typedef enum logic [1:0] {
		SPCG_RUN,
		SPCG_SLEEP,
		SPCG_DEEP
	} spcg_mode_t;
	// peripheral access request and answer
	typedef struct packed {
		logic req;
		logic [2:0] sel;
	} spcg_pacc_t;
	typedef struct packed {
		logic ok;
		logic fault;
	} spcg_pans_t;
endpackage

// ===== hw/spcg_glitchless.sv
`timescale 1ns/1ps
// glitch-free clock gate: enable latched while clock is low
module spcg_glitchless (
	// clock and enable
	input wire logic clk_in,
	input wire logic en_in,
	// gated clock
	output logic gclk_out
);
	logic en_lat;

	// latch transparent on low phase so enable never changes mid-pulse
	always_latch begin
		if (!clk_in) begin
			en_lat <= en_in;
		end
	end

	assign gclk_out = clk_in & en_lat;
endmodule // spcg_glitchless

// ===== hw/spcg_top.sv
`timescale 1ns/1ps
// Functional notes
// R1: gate bit 1 clocks the peripheral; 0 stops clock and holds it disabled.
// R2: access to a peripheral whose clock is off answers with a bus fault.
// R3: all gating bits clear to zero at reset.
// R4: run, sleep and deep-sleep gate registers; sleep one at 0x114.
// R5: sleep settings only apply when auto clock gating select is set.
// R6: bits 18, 17, 16 gate timers 2, 1, 0; read and write.
// R7: bit 14 gates two-wire b, bit 12 two-wire a; read and write.
// R8: bit 5 gates sync serial b, bit 4 sync serial a; read and write.
// R9: bit 0 gates uart a; read and write.
// R10: reserved bits read zero; software should preserve them.
// R11: switching between run and sleep enables is glitch free.
module spcg_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [11:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// power mode from the system
	input wire spcg_pkg::spcg_mode_t mode_in,
	// peripheral access checking
	input wire spcg_pkg::spcg_pacc_t pacc_in,
	output spcg_pkg::spcg_pans_t pans_out,
	// per-peripheral enables and gated clocks
	output logic [spcg_pkg::NUM_PERIPH-1:0] periph_en_out,
	output logic [spcg_pkg::NUM_PERIPH-1:0] periph_clk_out
);
	// gate registers and the run clock configuration
	logic [31:0] run_gate_ff;
	logic [31:0] nxt_run_gate;
	logic [31:0] sleep_gate_ff;
	logic [31:0] nxt_sleep_gate;
	logic [31:0] deep_gate_ff;
	logic [31:0] nxt_deep_gate;
	logic [31:0] run_cfg_ff;
	logic [31:0] nxt_run_cfg;

	// read return path
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// selected gate word, enables and access answer
	logic [31:0] sel_gate;
	logic [spcg_pkg::NUM_PERIPH-1:0] en_ff;
	logic [spcg_pkg::NUM_PERIPH-1:0] nxt_en;
	spcg_pkg::spcg_pans_t pans_ff;
	spcg_pkg::spcg_pans_t nxt_pans;

	// only the auto gating select survives a config write
	localparam logic [31:0] ACG_MASK = 32'h0000_0001 << spcg_pkg::ACG_POS;

	// which register an address names
	typedef enum logic [2:0] {
		SPCG_REG_NONE,
		SPCG_REG_RUN,
		SPCG_REG_SLEEP,
		SPCG_REG_DEEP,
		SPCG_REG_CFG
	} spcg_reg_t;

	// masked write keeps reserved bits at zero
	function automatic logic [31:0] wmask(input logic [31:0] d);
		return d & spcg_pkg::GATE_WMASK; // see R10
	endfunction

	// one decode for both strobes, so reads and writes never disagree
	function automatic spcg_reg_t reg_decode(input logic [11:0] a);
		spcg_reg_t r;
		r = SPCG_REG_NONE;
		unique case (a)
			spcg_pkg::RUN_GATE_OFS: r = SPCG_REG_RUN;
			spcg_pkg::SLEEP_GATE_OFS: r = SPCG_REG_SLEEP;
			spcg_pkg::DEEP_GATE_OFS: r = SPCG_REG_DEEP;
			spcg_pkg::RUN_CFG_OFS: r = SPCG_REG_CFG;
			default: r = SPCG_REG_NONE;
		endcase
		return r;
	endfunction

	// register writes; reserved bits never take a one
	always_comb begin
		nxt_run_gate = run_gate_ff;
		nxt_sleep_gate = sleep_gate_ff;
		nxt_deep_gate = deep_gate_ff;
		nxt_run_cfg = run_cfg_ff;
		if (wr_in) begin
			unique case (reg_decode(addr_in))
				SPCG_REG_RUN: begin
					nxt_run_gate = wmask(wdata_in);
				end
				SPCG_REG_SLEEP: begin
					nxt_sleep_gate = wmask(wdata_in); // see R4, R6, R7, R8, R9
				end
				SPCG_REG_DEEP: begin
					nxt_deep_gate = wmask(wdata_in);
				end
				SPCG_REG_CFG: begin
					// other config fields live elsewhere, not in this block
					nxt_run_cfg = wdata_in & ACG_MASK;
				end
				default: begin
					nxt_run_cfg = run_cfg_ff; // unmapped writes are dropped
				end
			endcase
		end
	end

	// read data, one cycle later; unmapped and idle cycles read zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (rd_in) begin
			unique case (reg_decode(addr_in))
				SPCG_REG_RUN: begin
					nxt_rdata = run_gate_ff;
				end
				SPCG_REG_SLEEP: begin
					nxt_rdata = sleep_gate_ff; // see R10
				end
				SPCG_REG_DEEP: begin
					nxt_rdata = deep_gate_ff;
				end
				SPCG_REG_CFG: begin
					nxt_rdata = run_cfg_ff;
				end
				default: begin
					nxt_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// mode selection: sleep registers only used with auto gating select
	always_comb begin
		sel_gate = run_gate_ff;
		nxt_en = '0;
		if (run_cfg_ff[spcg_pkg::ACG_POS]) begin // see R5
			unique case (mode_in)
				spcg_pkg::SPCG_RUN: begin
					sel_gate = run_gate_ff;
				end
				spcg_pkg::SPCG_SLEEP: begin
					sel_gate = sleep_gate_ff; // see R4
				end
				spcg_pkg::SPCG_DEEP: begin
					sel_gate = deep_gate_ff;
				end
				default: begin
					// unused mode code falls back to run gating, the safe side
					sel_gate = run_gate_ff;
				end
			endcase
		end
		for (int i = 0; i < spcg_pkg::NUM_PERIPH; i++) begin
			nxt_en[i] = sel_gate[spcg_pkg::GATE_POS[i]]; // see R1
		end
	end

	// access check against the enables in force this cycle
	// limitation: the fault is a port flag, the bus itself is elsewhere
	always_comb begin
		nxt_pans = '0;
		if (pacc_in.req) begin
			nxt_pans.ok = en_ff[pacc_in.sel];
			nxt_pans.fault = !en_ff[pacc_in.sel]; // see R2
		end
	end

	// register group; reset leaves every peripheral unclocked
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_gate_ff <= spcg_pkg::GATE_RESET;
			sleep_gate_ff <= spcg_pkg::GATE_RESET; // see R3
			deep_gate_ff <= spcg_pkg::GATE_RESET;
			run_cfg_ff <= spcg_pkg::CFG_RESET;
		end else begin
			run_gate_ff <= nxt_run_gate;
			sleep_gate_ff <= nxt_sleep_gate;
			deep_gate_ff <= nxt_deep_gate;
			run_cfg_ff <= nxt_run_cfg;
		end
	end

	// read return register, zero outside the cycle after a read
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// enable register; a flop keeps decode hazards off the clock gates
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en_ff <= '0;
		end else begin
			en_ff <= nxt_en;
		end
	end

	// access answer register, one cycle after the request
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pans_ff <= '0;
		end else begin
			pans_ff <= nxt_pans;
		end
	end

	// outputs straight from their flops
	assign rdata_out = rdata_ff;
	assign pans_out = pans_ff;
	assign periph_en_out = en_ff; // disabled while clock is off, see R1

	// one glitch-free gate per peripheral
	genvar g;
	generate
		for (g = 0; g < spcg_pkg::NUM_PERIPH; g++) begin : g_gate
			spcg_glitchless u_gate (
				.clk_in(clk_in),
				.en_in(en_ff[g]), // see R11
				.gclk_out(periph_clk_out[g])
			);
		end
	endgenerate
endmodule // spcg_top

// ===== tb/spcg_sva.sv
`timescale 1ns/1ps
// watches read data, access answers and enables at the top ports
module spcg_sva (
	// clock, reset and register port
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [11:0] addr_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	// mode, access check and enables
	input wire spcg_pkg::spcg_mode_t mode_in,
	input wire spcg_pkg::spcg_pacc_t pacc_in,
	input wire spcg_pkg::spcg_pans_t pans_out,
	input wire logic [spcg_pkg::NUM_PERIPH-1:0] periph_en_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// a read of the sleep gate register
	sequence seq_slp_rd;
		rd_in && addr_in == spcg_pkg::SLEEP_GATE_OFS;
	endsequence
	AST_RSV_ZERO: assert property (seq_slp_rd |=>
		(rdata_out & ~spcg_pkg::GATE_WMASK) == '0) else $error("reserved bit");
	AST_RD_IDLE: assert property (!rd_in |=> rdata_out == '0)
		else $error("read data outside read");
	AST_UNMAP: assert property (rd_in && addr_in == 12'h0200 |=>
		rdata_out == '0) else $error("unmapped read not zero");
	AST_FAULT: assert property (pacc_in.req &&
		!periph_en_out[pacc_in.sel] |=> pans_out == 2'h1) else $error("no fault");
	AST_OK: assert property (pacc_in.req &&
		periph_en_out[pacc_in.sel] |=> pans_out == 2'h2) else $error("no ok");
	AST_NOREQ: assert property (!pacc_in.req |=> pans_out == '0)
		else $error("answer without request");
	AST_RST: assert property ($rose(rst_n_in) |->
		periph_en_out == '0 && rdata_out == '0) else $error("reset value");
	// quiet bus and steady mode leave enables alone, no glitching
	AST_HOLD: assert property ((!wr_in && $stable(mode_in))[*3] |=>
		$stable(periph_en_out)) else $error("enable moved");
endmodule // spcg_sva
bind spcg_top spcg_sva u_sva (.clk_in, .rst_n_in, .addr_in, .wr_in, .rd_in,
	.rdata_out, .mode_in, .pacc_in, .pans_out, .periph_en_out);

// ===== tb/spcg_top_tb.sv
`timescale 1ns/1ps
module spcg_top_tb;
	logic clk_in = 0;
	logic rst_n_in = 0;
	logic [11:0] addr_in = '0;
	logic [31:0] wdata_in = '0;
	logic wr_in = 0;
	logic rd_in = 0;
	logic [31:0] rdata_out;
	spcg_pkg::spcg_mode_t mode_in = spcg_pkg::SPCG_RUN;
	spcg_pkg::spcg_pacc_t pacc_in = '0;
	spcg_pkg::spcg_pans_t pans_out;
	logic [7:0] en;
	logic [7:0] gclk;
	int errors = 0;
	int num_checks = 0;
	// 50 MHz system clock
	always #10 clk_in = ~clk_in;
	spcg_top dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .mode_in, .pacc_in, .pans_out, .periph_en_out(en),
		.periph_clk_out(gclk));
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %0t %h %h", $time, got, exp);
		end
	endtask
	// each access waits an edge first, so strobes never collide
	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1;
		@(posedge clk_in);
		wr_in <= 0;
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] exp);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1;
		@(posedge clk_in);
		rd_in <= 0;
		#1 chk(rdata_out, exp);
	endtask
	task automatic acc(logic [2:0] s, logic [1:0] exp);
		@(posedge clk_in);
		pacc_in <= '{1'b1, s};
		@(posedge clk_in);
		pacc_in.req <= 0;
		#1 chk(32'(pans_out), 32'(exp));
	endtask
	task automatic complete_run();
		if (errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one peripheral at a time in sleep: own access ok, neighbour faults
	initial begin
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1;
		rd(spcg_pkg::SLEEP_GATE_OFS, '0);
		wr(spcg_pkg::RUN_CFG_OFS, 32'h0800_0000);
		mode_in <= spcg_pkg::SPCG_SLEEP;
		wr(spcg_pkg::SLEEP_GATE_OFS, 32'hFFFF_FFFF);
		rd(spcg_pkg::SLEEP_GATE_OFS, spcg_pkg::GATE_WMASK);
		rd(spcg_pkg::RUN_CFG_OFS, 32'h0800_0000);
		for (int i = 0; i < 8; i++) begin
			wr(spcg_pkg::SLEEP_GATE_OFS, 32'h0000_0001 << spcg_pkg::GATE_POS[i]);
			repeat (3) @(posedge clk_in);
			chk(en, 32'h0000_0001 << i);
			#5 chk(gclk, 32'h0000_0001 << i);
			#10 chk(gclk, '0);
			acc(3'(i), 2'h2);
			acc(3'((i + 1) % 8), 2'h1);
		end
		// deep register in deep mode: every peripheral clocked
		wr(spcg_pkg::DEEP_GATE_OFS, 32'hFFFF_FFFF);
		rd(spcg_pkg::DEEP_GATE_OFS, spcg_pkg::GATE_WMASK);
		@(posedge clk_in);
		mode_in <= spcg_pkg::SPCG_DEEP;
		repeat (3) @(posedge clk_in);
		chk(en, 32'h0000_00FF);
		acc(3'h3, 2'h2);
		@(posedge clk_in);
		mode_in <= spcg_pkg::SPCG_RUN;
		repeat (3) @(posedge clk_in);
		chk(en, '0);
		wr(spcg_pkg::RUN_CFG_OFS, '0);
		mode_in <= spcg_pkg::SPCG_SLEEP;
		wr(spcg_pkg::RUN_GATE_OFS, 32'h0000_0001);
		repeat (3) @(posedge clk_in);
		chk(en, 32'h0000_0001);
		rd(spcg_pkg::RUN_GATE_OFS, 32'h0000_0001);
		rd(12'h0200, '0);
		// reset in mid-run clears every gate again
		@(posedge clk_in);
		rst_n_in <= 0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1;
		@(posedge clk_in);
		chk(en, '0);
		rd(spcg_pkg::RUN_GATE_OFS, '0);
		rd(spcg_pkg::SLEEP_GATE_OFS, '0);
		complete_run();
	end
endmodule // spcg_top_tb
